//--- design/mvi_pkg.sv
package mvi_pkg;
  // Timing of the operating cycle.
  localparam int CLK_MHZ = 100;
  localparam int CYCLE_US = 1024;
  localparam int CYCLE_CLKS = CYCLE_US * CLK_MHZ;
  localparam int SUB_CYCLES = 8;
  localparam int SUB_STEPS = 16;
  // Host bus field positions.
  localparam int BUS_NIB_LSB = 12;
  localparam int BUS_SEL_LSB = 0;
  // Slice codes and sequence landmarks.
  localparam logic [1:0] SLICE_LOW = 2'h0;
  localparam logic [1:0] SLICE_MID = 2'h1;
  localparam logic [1:0] SLICE_HIGH = 2'h2;
  localparam logic [2:0] LAST_SUB = 3'h7;
  localparam logic [3:0] LAST_STEP = 4'hF;
  localparam logic [3:0] X_LOW_STEP = 4'h9;
  localparam logic [3:0] X_HIGH_STEP = 4'hB;
  localparam logic [6:0] QTR_TURN = 7'h20;
  // Reset values.
  localparam logic [3:0] ACC_RST = 4'h0;
  localparam logic [3:0] VEL_RST = 4'h0;
  localparam logic [7:0] DAC_MID = 8'h80;
  // Control store, one word per step: bit 3 write, bit 2 Y axis, bits 1:0 slice.
  localparam logic [15:0][3:0] CTL_STORE = {4'hE, 4'hD, 4'hC, 4'h0, 4'hA, 4'h9, 4'h8,
    4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0, 4'h0};
  // Quarter-wave sine, amplitude 100, entries 0 to 32.
  localparam logic [32:0][7:0] SINE_QTR = {8'h64, 8'h64, 8'h64, 8'h63, 8'h62, 8'h61,
    8'h60, 8'h5E, 8'h5C, 8'h5A, 8'h58, 8'h56, 8'h53, 8'h50, 8'h4D, 8'h4A, 8'h47, 8'h43,
    8'h3F, 8'h3C, 8'h38, 8'h33, 8'h2F, 8'h2B, 8'h26, 8'h22, 8'h1D, 8'h18, 8'h14, 8'h0F,
    8'h0A, 8'h05, 8'h00};
endpackage : mvi_pkg

//--- design/mvi_interpolator.sv
module mvi_interpolator
  import mvi_pkg::*;
#(
  parameter int CYCLE_CLKS_P = CYCLE_CLKS
) (
  input wire logic clk,
  input wire logic rst_b,
  input wire logic velocity_write_strobe,
  input wire logic [15:0] bus_data,
  input wire logic request_acknowledge,
  output logic irq_request,
  output logic [1:0] lookup_sel,
  output logic [7:0] dac_data,
  output logic harm_sample,
  output logic [3:0] phase_sample,
  output logic ref_low_power
);

  localparam int STEP_CLKS = CYCLE_CLKS_P / (SUB_CYCLES * SUB_STEPS);

  typedef struct packed {
    logic [16:0] div;
    logic [3:0] step;
    logic [2:0] sub;
    logic started;
    logic carry;
    logic [1:0][2:0][3:0] acc;
    logic [3:0][3:0] vel;
    logic irq;
    logic [7:0] dac;
    logic [1:0] sel;
    logic harm;
    logic [3:0] phase;
    logic low_power;
  } mvi_state_s;

  localparam mvi_state_s RST_STATE = '{
    div: '0, step: '0, sub: '0, started: 1'b0, carry: 1'b0,
    acc: {6{ACC_RST}}, vel: {4{VEL_RST}}, irq: 1'b0, dac: DAC_MID,
    sel: 2'h0, harm: 1'b0, phase: 4'h0, low_power: 1'b0};

  // One-hot write enable for the three slices of one accumulator.
  function automatic logic [2:0] slice_dec(input logic [1:0] sl, input logic we);
    logic [2:0] d;
    d = 3'h0;
    if (we) begin
      d[sl] = 1'b1;
    end
    return d;
  endfunction : slice_dec

  // Signed sine of a 7-bit phase, built from the quarter table by symmetry.
  function automatic logic signed [7:0] sine7(input logic [6:0] p);
    logic [5:0] q;
    logic [7:0] mag;
    q = p[5] ? 6'(6'h20 - {1'b0, p[4:0]}) : {1'b0, p[4:0]};
    mag = SINE_QTR[q];
    return p[6] ? -signed'(mag) : signed'(mag);
  endfunction : sine7

  // Offset-binary lookup content for one function select.
  function automatic logic [7:0] rom_byte(input logic [6:0] p, input logic [1:0] fsel);
    logic [6:0] ph;
    logic [6:0] ph3;
    logic signed [7:0] f8;
    logic signed [7:0] h8;
    logic signed [9:0] val;
    ph = fsel[1] ? p : 7'(p + QTR_TURN);
    ph3 = 7'(ph + {ph[5:0], 1'b0});
    f8 = sine7(ph);
    h8 = sine7(ph3);
    val = {{4{h8[7]}}, h8[7:2]};
    if (fsel[0]) begin
      val = val + {{2{f8[7]}}, f8};
    end
    val = val + signed'({2'b00, DAC_MID});
    return val[7:0];
  endfunction : rom_byte

  // One 4-bit lookup half; two of them make up the converter byte.
  function automatic logic [3:0] rom_nib(input logic [6:0] p, input logic [1:0] fsel,
                                        input logic upper);
    logic [7:0] b;
    b = rom_byte(p, fsel);
    return upper ? b[7:4] : b[3:0];
  endfunction : rom_nib

  mvi_state_s s;
  mvi_state_s n;
  logic step_en;
  logic [3:0] ctl;
  logic axis;
  logic [1:0] slice;
  logic carry_in;
  logic [3:0] a_nib;
  logic [3:0] b_nib;
  logic [4:0] sum;
  logic window;
  logic [3:0] load_step;
  logic [1:0] chan;
  logic [6:0] addr;
  logic [2:0] wen;

  // Next-state logic: step divider, serial slice adder, host capture and DAC sequence.
  always_comb begin
    n = s;
    wen = 3'h0;
    step_en = (s.div == 17'(STEP_CLKS - 1));
    ctl = CTL_STORE[s.step];
    axis = ctl[2];
    slice = ctl[1:0];
    // Step 0 recurs every 16 step pulses; carry in is held low there.
    carry_in = (s.step == 4'h0) ? 1'b0 : s.carry;
    a_nib = s.acc[axis][slice];
    unique case (slice)
      SLICE_LOW: b_nib = s.vel[{axis, 1'b0}];
      SLICE_MID: b_nib = s.vel[{axis, 1'b1}];
      default: b_nib = {4{s.vel[{axis, 1'b1}][3]}};
    endcase
    sum = {1'b0, a_nib} + {1'b0, b_nib} + {4'h0, carry_in};
    window = (s.sub == LAST_SUB) && ctl[3] && ctl[2];
    load_step = step_en ? 4'(s.step + 4'h1) : s.step;
    chan = load_step[2:1];
    addr = {s.acc[chan[1]][2][2:0], s.acc[chan[1]][1]};

    // Divider and sequencing counters; eight sub-cycles of 16 steps each.
    if (step_en) begin
      n.div = '0;
      n.step = 4'(s.step + 4'h1);
      if (s.step == LAST_STEP) begin
        n.sub = 3'(s.sub + 3'h1);
      end
    end else if (s.started) begin
      // The start edge keeps the divider at zero so the first step is as long as the others.
      n.div = 17'(s.div + 17'h1);
    end

    // Slice write decode, gated by the step pulse and the control write bit.
    if (step_en) begin
      for (int ax = 0; ax < 2; ax++) begin
        wen = slice_dec(slice, ctl[3] && (axis == ax[0]));
        for (int sl = 0; sl < 3; sl++) begin
          if (wen[sl]) begin
            n.acc[ax][sl] = sum[3:0];
          end
        end
      end
      // Idle steps discard the carry so the Y slot never sees the X carry.
      n.carry = ctl[3] ? sum[4] : 1'b0;
    end

    // Host capture only inside the Y slot of the last sub-cycle.
    if (velocity_write_strobe && window) begin
      n.vel[bus_data[BUS_SEL_LSB +: 2]] = bus_data[BUS_NIB_LSB +: 4];
    end
    n.low_power = (s.vel == '0);

    // Request: cleared by acknowledge, set at each cycle start; the set wins.
    if (request_acknowledge) begin
      n.irq = 1'b0;
    end
    if (!s.started || (step_en && s.step == LAST_STEP && s.sub == LAST_SUB)) begin
      n.irq = 1'b1;
    end
    n.started = 1'b1;

    // Converter sequence in steps 0 to 7: harmonic then fundamental per channel.
    if (step_en || !s.started) begin
      if (!load_step[3]) begin
        n.sel = {chan[0] ^ chan[1], load_step[0]};
        n.harm = !load_step[0];
        n.phase = load_step[0] ? 4'(4'h1 << chan) : 4'h0;
        n.dac = {rom_nib(addr, n.sel, 1'b1), rom_nib(addr, n.sel, 1'b0)};
      end else begin
        n.harm = 1'b0;
        n.phase = 4'h0;
      end
    end
  end

  // State register; reset loads constants only.
  always_ff @(posedge clk or negedge rst_b) begin
    if (!rst_b) begin
      s <= RST_STATE;
    end else begin
      s <= n;
    end
  end

  // All outputs come straight from the state register.
  assign irq_request = s.irq;
  assign lookup_sel = s.sel;
  assign dac_data = s.dac;
  assign harm_sample = s.harm;
  assign phase_sample = s.phase;
  assign ref_low_power = s.low_power;

  default clocking cb @(posedge clk);
  endclocking
  default disable iff (!rst_b);

  irq_cycle_start_a: assert property (
    $rose(irq_request) |-> (s.step == 4'h0) && (s.sub == 3'h0))
    else $error("request rose away from cycle start");

  irq_each_cycle_a: assert property (
    (step_en && s.step == LAST_STEP && s.sub == LAST_SUB) |=> irq_request)
    else $error("request not raised at cycle start");

  sub_advance_a: assert property (
    (step_en && s.step == LAST_STEP) |=> s.sub == 3'($past(s.sub) + 3'h1))
    else $error("sub-cycle did not advance after 16 steps");

  carry_clear_a: assert property (
    (step_en && s.step == 4'h0) |=> !s.carry)
    else $error("carry not cleared at step zero");

  carry_chain_a: assert property (
    (step_en && ctl[3] && s.step != LAST_STEP) |=> ##1 carry_in == $past(sum[4], 2))
    else $error("carry out not passed to next slice");

  low_slice_a: assert property (
    (step_en && s.step == X_LOW_STEP) |=> s.acc[0][0] ==
      4'($past(s.acc[0][0]) + $past(s.vel[0]) + {3'h0, $past(s.carry)}))
    else $error("X low slice sum wrong");

  high_slice_a: assert property (
    (step_en && s.step == X_HIGH_STEP) |=> s.acc[0][2] ==
      4'($past(s.acc[0][2]) + {4{$past(s.vel[1][3])}} + {3'h0, $past(s.carry)}))
    else $error("X high slice sum wrong");

  idle_hold_a: assert property (
    (!step_en || !ctl[3]) |=> $stable(s.acc))
    else $error("accumulator written without write decode");

  vel_capture_a: assert property (
    (velocity_write_strobe && window) |=>
      s.vel[$past(bus_data[1:0])] == $past(bus_data[15:12]))
    else $error("velocity nibble not captured");

  vel_refuse_a: assert property (
    !(velocity_write_strobe && window) |=> $stable(s.vel))
    else $error("velocity changed outside capture slot");

  sequence harm_end_s;
    $fell(harm_sample);
  endsequence
  sequence fund_on_s;
    (phase_sample != 4'h0) && lookup_sel[0];
  endsequence

  harm_then_fund_a: assert property (
    harm_end_s |-> fund_on_s)
    else $error("fundamental did not follow harmonic");

  // Checked on the entry edge only; later clocks of the step no longer see the harmonic.
  chan_order_a: assert property (
    $rose(phase_sample[2]) |-> (lookup_sel == 2'h3) && $past(harm_sample) &&
      ($past(lookup_sel) == 2'h2))
    else $error("Y sine channel out of order");

  low_power_a: assert property (
    (s.vel == '0) |=> ref_low_power)
    else $error("reference not reduced while stationary");

  // The middle slice takes the upper nibble and the carry of the low slice.
  mid_slice_a: assert property (
    (step_en && s.step == 4'(X_LOW_STEP + 4'h1)) |=> s.acc[0][1] ==
      4'($past(s.acc[0][1]) + $past(s.vel[1]) + {3'h0, $past(s.carry)}))
    else $error("X middle slice sum wrong");

  // The converter word may only move on a step boundary, so each value stands a whole step.
  dac_hold_a: assert property (
    (!step_en && s.started) |=> $stable(dac_data))
    else $error("converter word changed inside a step");

  // An acknowledge drops the request unless a cycle start sets it again in the same clock.
  irq_ack_clear_a: assert property (
    (request_acknowledge && s.started &&
      !(step_en && s.step == LAST_STEP && s.sub == LAST_SUB)) |=> !irq_request)
    else $error("request not cleared by acknowledge");

endmodule : mvi_interpolator

//--- verif/mvi_host_model.sv
// Behavioural host that answers the request and sends velocity nibbles.
module mvi_host_model #(
  parameter int VX = 0,
  parameter int VY = 0
) (
  input wire logic clk,
  input wire logic irq_request,
  output logic velocity_write_strobe,
  output logic [15:0] bus_data,
  output logic request_acknowledge
);
  timeunit 1ns;
  timeprecision 1ns;
  logic irq_q = 1'b0;
  logic [15:0] vel = {8'(VY), 8'(VX)};
  logic strobe_q = 1'b0;
  logic [15:0] bus_q = 16'hA5A5;
  logic ack_q = 1'b0;
  int cnt = 0;
  // One process drives each pin; the registers start at a known level.
  assign velocity_write_strobe = strobe_q;
  assign bus_data = bus_q;
  assign request_acknowledge = ack_q;
  // The host counts clocks from each request so it writes inside the capture window.
  // An idle bus inverts every clock so a stale word can never pass for data.
  always @(negedge clk) begin
    cnt = (irq_request && !irq_q) ? 0 : cnt + 1;
    irq_q = irq_request;
    ack_q <= irq_request && cnt == 0;
    if (cnt >= 1000 && cnt <= 1003) begin
      strobe_q <= 1'b1;
      bus_q <= {4'(vel >> (4 * (cnt - 1000))), 10'h000, 2'(cnt - 1000)};
    end else if (cnt == 100) begin
      strobe_q <= 1'b1; // A stray write outside the window.
      bus_q <= {4'h7, 10'h000, 2'h1};
    end else begin
      strobe_q <= 1'b0;
      bus_q <= ~bus_q;
    end
  end
endmodule : mvi_host_model

//--- verif/mvi_interpolator_test.sv
module mvi_interpolator_test
  import mvi_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int VX = 90;
  localparam int VY = -90;
  logic clk = 1'b0;
  logic rst_b = 1'b0;
  logic strobe, ack, irq, harm, refl;
  logic [15:0] bus;
  logic [1:0] sel;
  logic [7:0] dac;
  logic [3:0] ph;
  int t = -1;
  int cyc = 0;
  int n_mismatch = 0;
  int cmp_count = 0;

  // Small cycle length gives eight clocks a step and 1024 clocks a cycle.
  mvi_interpolator #(.CYCLE_CLKS_P(1024)) DUT (.clk(clk), .rst_b(rst_b),
    .velocity_write_strobe(strobe), .bus_data(bus), .request_acknowledge(ack),
    .irq_request(irq), .lookup_sel(sel), .dac_data(dac), .harm_sample(harm),
    .phase_sample(ph), .ref_low_power(refl));
  mvi_host_model #(.VX(VX), .VY(VY)) host (.clk(clk), .irq_request(irq),
    .velocity_write_strobe(strobe), .bus_data(bus), .request_acknowledge(ack));

  always #5 clk = ~clk;

  // Clock index since the first cycle start, plus the hang limit.
  always @(posedge clk) begin
    if (rst_b) t <= t + 1;
    cyc++;
    if (cyc == 4000) begin
      n_mismatch++;
      give_verdict();
    end
  end

  function automatic int sn(int i);
    i = i & 127;
    if (i <= 32) return int'(SINE_QTR[i]);
    if (i <= 64) return int'(SINE_QTR[64 - i]);
    if (i <= 96) return -int'(SINE_QTR[i - 64]);
    return -int'(SINE_QTR[128 - i]);
  endfunction : sn

  task automatic cmp(logic [7:0] got, logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h exp %h", $time, got, exp);
    end
  endtask : cmp

  task automatic at_clk(int n);
    while (t != n) @(negedge clk);
  endtask : at_clk

  // Walks steps 0 to 8 of one sub-cycle; nx and ny are the adds each accumulator has seen.
  task automatic check_sub(int c, int u, int nx, int ny);
    int a, p, h, sl;
    for (int s = 0; s < 9; s++) begin
      at_clk(c * 1024 + u * 128 + s * 8 + 4);
      sl = (16'h4EE4 >> (2 * s)) & 3;
      if (s == 8) begin
        cmp(8'(harm), 8'h00);
        cmp(8'(ph), 8'h00);
      end else begin
        cmp(8'(sel), 8'(sl));
        cmp(8'(harm), 8'(s % 2 == 0));
        cmp(8'(ph), 8'((s % 2) << (s / 2)));
        a = ((s < 4 ? VX * nx : VY * ny) >>> 4) & 127;
        p = a + (sl[1] ? 0 : 32);
        h = sn(3 * p) >>> 2;
        cmp(dac, 8'(128 + h + (sl[0] ? sn(p) : 0)));
      end
    end
  endtask : check_sub

  task automatic test_reset();
    repeat (8) @(negedge clk);
    cmp(dac, 8'h80);
    cmp(8'(irq), 8'h00);
    cmp({harm, ph, refl, sel}, 8'h00);
    repeat (8) @(negedge clk);
    rst_b = 1'b1;
    at_clk(0);
    cmp(8'(irq), 8'h01);
    at_clk(3);
    cmp(8'(irq), 8'h00);
    check_sub(0, 0, 0, 0);
    cmp(8'(refl), 8'h01);
  endtask : test_reset

  // Motion with carries through every slice and a refused stray write.
  task automatic test_motion();
    at_clk(1023);
    cmp(8'(irq), 8'h00);
    at_clk(1024);
    cmp(8'(irq), 8'h01);
    for (int u = 0; u < 8; u++) check_sub(1, u, u, u + 1);
    cmp(8'(refl), 8'h00);
    check_sub(2, 0, 8, 9);
    check_sub(2, 7, 15, 16);
  endtask : test_motion

  task automatic give_verdict();
    if (n_mismatch == 0 && cmp_count > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : give_verdict

  initial begin
    test_reset();
    test_motion();
    give_verdict();
  end
endmodule : mvi_interpolator_test
